// ==== src/fence_counter.sv ====
// Purpose: Saturating count of outstanding memory operations
// Assumes: Increment and decrement may come in the same cycle
// Notes: Reports empty when no operation is outstanding
`timescale 1ns/10ps
module fence_counter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Count events
  input wire logic inc,
  input wire logic dec,
  // Status
  output logic empty
);

  typedef struct packed {
    logic [fence_pkg::cnt_w-1:0] count;
  } cnt_state_t;

  cnt_state_t state;
  cnt_state_t next_state;

  always_comb begin
    next_state = state;
    if (inc && !dec && state.count != fence_pkg::cnt_max) begin
      next_state.count = state.count + fence_pkg::cnt_one;
    end else if (dec && !inc && state.count != fence_pkg::cnt_zero) begin
      next_state.count = state.count - fence_pkg::cnt_one;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign empty = (state.count == fence_pkg::cnt_zero);

endmodule

// ==== src/fence_pkg.sv ====
// Purpose: Shared types and constants for the memory ordering fence unit
// Assumes: Single core clock, synchronous active-high reset
// Notes: Operation classes arrive one per cycle from the issue stage
package fence_pkg;

  // Operation classes seen at issue
  typedef enum logic [3:0] {
    op_none,
    op_load,
    op_store,
    op_nt_store,
    op_full_fence,
    op_store_fence_op,
    op_identify_op,
    op_serialize,
    op_locked_rmw,
    op_swap
  } op_kind_t;

  localparam int cnt_w = 4;
  localparam logic [cnt_w-1:0] cnt_zero = 4'h0;
  localparam logic [cnt_w-1:0] cnt_one = 4'h1;
  localparam logic [cnt_w-1:0] cnt_max = 4'hf;

  // Issue request from the instruction stream
  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic writeback_type;
    logic aligned;
    logic line_shared;
  } issue_req_t;

  // Completion and drain status from the cache side
  typedef struct packed {
    logic load_done;
    logic store_done;
    logic prefetch_done;
    logic older_retired_all;
    logic wc_empty;
    logic line_modified;
    logic lock_done;
  } mem_status_t;

  // Lock control toward the cache side
  typedef struct packed {
    logic want_modified;
    logic line_lock;
    logic bus_lock;
  } lock_ctrl_t;

endpackage

// ==== src/memory_ordering_fence_unit.sv ====
// Purpose: Ordering and fence control for the load/store issue path
// Assumes: Issue holds its request until accepted; cache reports completions
// Notes: Loads, stores and prefetches tracked by counters
//
// Functional notes
// (RL1) Writeback memory keeps all orders except younger load passing older store.
// (RL2) Streaming stores may reorder among themselves until a barrier.
// (RL3) Full fence, locked RMW, serializing op stop loads passing older stores.
// (RL4) Swap with memory is always locked with full barrier effect.
// (RL5) Full fence stalls issue until all older work and memory finish.
// (RL6) Serializing ops such as identify stall exactly like full fence.
// (RL7) Locked ops order memory without stalling independent instructions.
// (RL8) Locked op on shared line first gains modified state.
// (RL9) Misaligned locked op uses a global bus lock.
// (RL10) Locked identity RMW still acts as full barrier.
// (RL11) Store fence holds later stores until write-combining drains.
// (RL12) Store-to-load mechanisms also enforce store-to-store order.
// (RL13) Software should lock an aligned, locally exclusive location.
// (RL14) Software should use the same width for the barrier location.
`timescale 1ns/10ps
module memory_ordering_fence_unit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Issue side
  input wire fence_pkg::issue_req_t req,
  output logic accept,
  output logic nonmem_go,
  // Memory side
  input wire fence_pkg::mem_status_t mst,
  input wire logic prefetch_issue,
  output fence_pkg::lock_ctrl_t lock,
  output logic store_go,
  output logic load_go,
  output logic serial_busy
);

  // ****************************************
  // State
  // ****************************************
  typedef enum {st_run, st_drain, st_lock_own, st_lock_wait} mode_t;

  typedef struct packed {
    mode_t mode;
    logic store_fence_op_hold;
    logic accept;
    logic nonmem_go;
    logic store_go;
    logic load_go;
    logic serial_busy;
    fence_pkg::lock_ctrl_t lock;
  } fence_state_t;

  fence_state_t state;
  fence_state_t next_state;
  logic loads_empty;
  logic stores_empty;
  logic pref_empty;
  logic is_mem_load;
  logic is_mem_store;
  logic is_lock;
  logic is_serial;
  logic is_nt_store;
  logic nonmem_ok;

  // ****************************************
  // Outstanding operation counters
  // ****************************************
  fence_counter u_loads (
    .sys_clk(sys_clk), .rst(rst),
    .inc(state.load_go), .dec(mst.load_done), .empty(loads_empty)
  );
  fence_counter u_stores (
    .sys_clk(sys_clk), .rst(rst),
    .inc(state.store_go), .dec(mst.store_done), .empty(stores_empty)
  );
  fence_counter u_pref (
    .sys_clk(sys_clk), .rst(rst),
    .inc(prefetch_issue), .dec(mst.prefetch_done), .empty(pref_empty)
  );

  // ****************************************
  // Decode
  // ****************************************
  assign is_mem_load = req.valid && req.kind == fence_pkg::op_load;
  assign is_nt_store = req.valid && req.kind == fence_pkg::op_nt_store;
  assign is_mem_store = req.valid && (req.kind == fence_pkg::op_store || is_nt_store);
  assign is_lock = req.valid &&
                   (req.kind == fence_pkg::op_locked_rmw ||
                    req.kind == fence_pkg::op_swap); // RL4 RL10
  assign is_serial = req.valid &&
                     (req.kind == fence_pkg::op_full_fence ||
                      req.kind == fence_pkg::op_identify_op ||
                      req.kind == fence_pkg::op_serialize); // RL6
  // Non-memory op that may flow past a locked op
  assign nonmem_ok = req.valid && !is_mem_load && !is_mem_store && !is_lock && !is_serial &&
                     !state.accept && req.kind != fence_pkg::op_store_fence_op;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.accept = 1'b0;
    next_state.nonmem_go = 1'b0;
    next_state.store_go = 1'b0;
    next_state.load_go = 1'b0;
    if (mst.wc_empty) begin
      next_state.store_fence_op_hold = 1'b0; // RL11
    end
    case (state.mode)
      st_run: begin
        if (state.accept) begin
          // Request already taken last cycle
        end else if (is_serial) begin
          next_state.mode = st_drain; // RL5 RL6
          next_state.serial_busy = 1'b1;
        end else if (is_lock) begin
          // Locked ops wait on older stores and line ownership, non-memory issue keeps flowing
          next_state.mode = st_lock_own; // RL3 RL7 RL12
          next_state.lock.want_modified = req.line_shared; // RL8
          next_state.lock.bus_lock = !req.aligned; // RL9
          next_state.lock.line_lock = req.aligned;
          next_state.accept = 1'b1;
        end else if (req.valid && req.kind == fence_pkg::op_store_fence_op) begin
          next_state.store_fence_op_hold = !mst.wc_empty; // RL2 RL11
          next_state.accept = 1'b1;
        end else if (is_mem_store) begin
          // Streaming stores held only by store fence, full fence, serializing ops or locks
          if (!state.store_fence_op_hold) begin // RL11 RL12
            next_state.store_go = 1'b1; // RL1 RL2
            next_state.accept = 1'b1;
          end
        end else if (is_mem_load) begin
          next_state.load_go = 1'b1; // RL1
          next_state.accept = 1'b1;
        end else if (req.valid) begin
          next_state.nonmem_go = 1'b1; // RL7 RL11
          next_state.accept = 1'b1;
        end
      end
      st_drain: begin
        if (mst.older_retired_all && loads_empty && stores_empty && pref_empty &&
            mst.wc_empty) begin
          next_state.mode = st_run; // RL5
          next_state.serial_busy = 1'b0;
          next_state.accept = 1'b1;
        end
      end
      st_lock_own: begin
        // Older stores and streaming data drain before the lock
        if (stores_empty && mst.wc_empty &&
            (!state.lock.want_modified || mst.line_modified)) begin // RL3 RL8 RL12
          next_state.mode = st_lock_wait;
        end
        if (nonmem_ok) begin
          next_state.nonmem_go = 1'b1; // RL7
          next_state.accept = 1'b1;
        end
      end
      st_lock_wait: begin
        if (mst.lock_done) begin
          next_state.mode = st_run;
          next_state.lock = '0;
        end
        // Independent work keeps flowing while the lock completes
        if (nonmem_ok) begin
          next_state.nonmem_go = 1'b1; // RL7
          next_state.accept = 1'b1;
        end
      end
      default: begin
        next_state.mode = st_run;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '{mode: st_run, default: '0};
    end else begin
      state <= next_state;
    end
  end

  assign accept = state.accept;
  assign nonmem_go = state.nonmem_go;
  assign store_go = state.store_go;
  assign load_go = state.load_go;
  assign serial_busy = state.serial_busy;
  assign lock = state.lock;

  // ****************************************
  // Checks
  // ****************************************
  sequence serial_seen;
    is_serial && state.mode == st_run && !state.accept;
  endsequence

  no_load_in_drain_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.mode == st_drain |=> !load_go && !store_go) // RL5
    else $error("Memory op issued while draining");
  serial_stall_a: assert property (@(posedge sys_clk) disable iff (rst)
    serial_seen |=> serial_busy && state.mode == st_drain) // RL6
    else $error("Serializing op did not stall");
  lock_no_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.mode == st_lock_own |=> !load_go) // RL3
    else $error("Load passed a locked op");
  misalign_bus_a: assert property (@(posedge sys_clk) disable iff (rst)
    is_lock && !req.aligned && state.mode == st_run && !state.accept
    |=> lock.bus_lock && !lock.line_lock) // RL9
    else $error("Misaligned lock without bus lock");
  shared_mod_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.mode == st_lock_own && lock.want_modified && !mst.line_modified
    |=> state.mode != st_lock_wait) // RL8
    else $error("Lock proceeded before line modified");
  store_fence_op_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.store_fence_op_hold |=> !store_go) // RL11
    else $error("Store passed store fence");
  swap_locked_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.kind == fence_pkg::op_swap && state.mode == st_run && !state.accept
    |=> state.mode == st_lock_own) // RL4
    else $error("Swap not treated as locked");
  lock_no_stall_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.mode == st_lock_own |-> !serial_busy) // RL7
    else $error("Locked op stalled pipeline");
  lock_nonmem_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.mode == st_lock_wait && nonmem_ok |=> nonmem_go && accept) // RL7
    else $error("Locked op held a non-memory op");
  identity_barrier_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.kind == fence_pkg::op_locked_rmw && state.mode == st_run &&
    !state.accept |=> accept && state.mode == st_lock_own) // RL10
    else $error("Locked RMW did not act as barrier");
  lock_store_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.mode == st_lock_wait |-> !store_go) // RL12
    else $error("Store passed locked op");
  wb_load_go_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_go |-> $past(state.mode) == st_run) // RL1
    else $error("Load issued outside run mode");
  nt_store_go_a: assert property (@(posedge sys_clk) disable iff (rst)
    is_nt_store && state.mode == st_run && !state.accept && !state.store_fence_op_hold
    |=> store_go) // RL2
    else $error("Streaming store not issued");

endmodule

// ==== tb/cache_side_model.sv ====
// Purpose: Cache side stand-in that answers issue and lock traffic
// Assumes: At most one retirement of each kind per step of the delay timer
// Notes: slow spaces completions five cycles apart and stretches lock answers to five and ten cycles
`timescale 1ns/10ps
module cache_side_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pace
  input wire logic slow,
  // From the unit, except prefetch_issue which the bench drives
  input wire logic store_go,
  input wire logic load_go,
  input wire logic prefetch_issue,
  input wire fence_pkg::lock_ctrl_t lock,
  // To the unit
  output fence_pkg::mem_status_t mst
);
  int st_n, ld_n, pf_n, tmr, lk_t;
  logic sd, lw, pd;
  always @(posedge sys_clk) begin
    if (rst) begin
      st_n = 0;
      ld_n = 0;
      pf_n = 0;
      tmr = 0;
      lk_t = 0;
      mst <= '0;
    end else begin
      tmr = (tmr >= (slow ? 4 : 0)) ? 0 : tmr + 1;
      sd = (tmr == 0) && (st_n > 0);
      lw = (tmr == 0) && (ld_n > 0);
      pd = (tmr == 0) && (pf_n > 0);
      st_n = st_n + int'(store_go) - int'(sd);
      ld_n = ld_n + int'(load_go) - int'(lw);
      pf_n = pf_n + int'(prefetch_issue) - int'(pd);
      lk_t = (|lock) ? lk_t + 1 : 0;
      mst.store_done <= sd;
      mst.load_done <= lw;
      mst.prefetch_done <= pd;
      mst.wc_empty <= (st_n == 0);
      mst.older_retired_all <= (st_n == 0) && (ld_n == 0) && (pf_n == 0);
      // Ownership gained only some cycles after it is asked for
      mst.line_modified <= lock.want_modified && (lk_t >= (slow ? 5 : 1));
      mst.lock_done <= (lk_t >= (slow ? 10 : 2)) && (st_n == 0) &&
                       (!lock.want_modified || mst.line_modified);
      if (mst.lock_done) begin
        lk_t = 0;
      end
    end
  end
endmodule

// ==== tb/memory_ordering_fence_unit_tb.sv ====
// Purpose: Self-checking bench for the memory ordering fence unit
// Assumes: Cache side model answers all completions
// Notes: Random plain traffic, then fences, locked ops and store fence
`timescale 1ns/10ps
module memory_ordering_fence_unit_tb;
  logic sys_clk = 0;
  logic rst = 1;
  logic slow = 0;
  logic prefetch_issue = 0;
  fence_pkg::issue_req_t req = '0;
  fence_pkg::mem_status_t mst;
  fence_pkg::lock_ctrl_t lock;
  fence_pkg::lock_ctrl_t lk;
  logic accept, nonmem_go, store_go, load_go, serial_busy, busy_seen, wc_seen;
  logic [2:0] gos;
  logic [31:0] seed = 32'h00000025;
  int failures = 0;
  int total_checks = 0;
  int waited;
  fence_pkg::op_kind_t plain[4] = '{fence_pkg::op_none, fence_pkg::op_load,
    fence_pkg::op_store, fence_pkg::op_nt_store};
  fence_pkg::op_kind_t serial[3] = '{fence_pkg::op_full_fence, fence_pkg::op_identify_op,
    fence_pkg::op_serialize};
  // Lock targets, mostly aligned and unshared
  logic [3:0] lk_al = 4'hd;
  logic [3:0] lk_sh = 4'h4;
  always #10 sys_clk = ~sys_clk;
  memory_ordering_fence_unit memory_ordering_fence_unit_i (.sys_clk(sys_clk), .rst(rst),
    .req(req), .accept(accept), .nonmem_go(nonmem_go), .mst(mst),
    .prefetch_issue(prefetch_issue), .lock(lock), .store_go(store_go), .load_go(load_go),
    .serial_busy(serial_busy));
  cache_side_model cache_side_model_i (.sys_clk(sys_clk), .rst(rst), .slow(slow),
    .store_go(store_go), .load_go(load_go), .prefetch_issue(prefetch_issue), .lock(lock),
    .mst(mst));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [2:0] exp_go(input fence_pkg::op_kind_t k);
    return {k == fence_pkg::op_store || k == fence_pkg::op_nt_store,
      k == fence_pkg::op_load, k == fence_pkg::op_none};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Holds the request until accepted, then snapshots the answer
  task automatic issue(input fence_pkg::op_kind_t k, input logic al, input logic sh);
    req.valid = 1'b1;
    req.kind = k;
    req.writeback_type = 1'b1;
    req.aligned = al;
    req.line_shared = sh;
    waited = 0;
    busy_seen = 1'b0;
    do begin
      @(negedge sys_clk);
      waited++;
      busy_seen = busy_seen | serial_busy;
    end while (accept !== 1'b1 && waited < 60);
    gos = {store_go, load_go, nonmem_go};
    lk = lock;
    wc_seen = mst.wc_empty;
    // Wait limit ran out
    if (accept !== 1'b1) begin
      failures++;
    end
    // Accept cycle ignores the request, so drop it for one cycle
    req.valid = 1'b0;
    @(negedge sys_clk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    chk({accept, store_go, load_go, nonmem_go, serial_busy, lock}, 8'h00);
    for (int i = 0; i < 40; i++) begin
      seed = xorshift(seed);
      issue(plain[seed[1:0]], seed[2], 1'b0);
      chk(8'(waited), 8'h01);
      chk({5'h0, gos}, {5'h0, exp_go(plain[seed[1:0]])});
    end
    slow = 1;
    for (int i = 0; i < 3; i++) begin
      prefetch_issue = 1;
      issue(fence_pkg::op_store, 1'b1, 1'b0);
      prefetch_issue = 0;
      issue(serial[i], 1'b1, 1'b0);
      chk({7'h0, busy_seen}, 8'h01);
      chk({7'h0, mst.older_retired_all}, 8'h01);
      issue(fence_pkg::op_load, 1'b1, 1'b0);
      chk(8'(waited), 8'h01);
    end
    for (int i = 0; i < 4; i++) begin
      issue(i < 2 ? fence_pkg::op_locked_rmw : fence_pkg::op_swap, lk_al[i], lk_sh[i]);
      chk({5'h0, lk}, {5'h0, lk_sh[i], lk_al[i], ~lk_al[i]});
      issue(fence_pkg::op_none, 1'b1, 1'b0);
      chk(8'(waited), 8'h01);
      issue(fence_pkg::op_load, 1'b1, 1'b0);
      chk({7'h0, waited > 1}, 8'h01);
    end
    repeat (3) issue(fence_pkg::op_nt_store, 1'b1, 1'b0);
    issue(fence_pkg::op_store_fence_op, 1'b1, 1'b0);
    issue(fence_pkg::op_load, 1'b1, 1'b0);
    chk(8'(waited), 8'h01);
    issue(fence_pkg::op_store, 1'b1, 1'b0);
    chk({7'h0, wc_seen}, 8'h01);
    chk({7'h0, waited > 1}, 8'h01);
    req.valid = 1'b0;
    repeat (20) @(negedge sys_clk);
    report_and_stop();
  end
  // Whole run needs well under a thousand cycles; allow ten thousand
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
